// File: sar_seq_pkg.sv
// Purpose: Shared constants and types of the converter sequencer
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes:   Times are counted in half converter clock cycles
package sar_seq_pkg;

   // ----------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------
   localparam logic [4:0] OFS_CTRL_A = 5'h00; // Control a
   localparam logic [4:0] OFS_CTRL_B = 5'h04; // Control b
   localparam logic [4:0] OFS_SEL    = 5'h08; // Input selection
   localparam logic [4:0] OFS_RES_LO = 5'h0c; // Result low byte
   localparam logic [4:0] OFS_RES_HI = 5'h10; // Result high byte
   localparam logic [4:0] OFS_PWR    = 5'h14; // Power reduction

   // ----------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------
   localparam int CA_ENABLE = 7; // Converter enable bit
   localparam int CA_START  = 6; // Conversion start bit
   localparam int CA_AUTO   = 5; // Auto trigger enable bit
   localparam int CA_DONE   = 4; // Done flag, write one clears
   localparam int CA_IE     = 3; // Interrupt enable
   localparam int SEL_ADJ   = 5; // Left adjust of result
   localparam int PWR_BIT   = 0; // Converter power reduce bit

   // ----------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------
   localparam logic [7:0] RST_BYTE  = 8'h00; // All registers
   localparam logic [9:0] RST_RES   = 10'h000;
   localparam logic [6:0] RST_PCNT  = 7'h00;
   localparam logic [5:0] RST_HALF  = 6'h00;

   // ----------------------------------------------------------
   // Conversion timing, in half converter cycles
   // ----------------------------------------------------------
   localparam logic [5:0] HALF_FIRST  = 6'h32; // 25 cycles
   localparam logic [5:0] HALF_NORMAL = 6'h1a; // 13 cycles
   localparam logic [5:0] HALF_AUTO   = 6'h1b; // 13.5 cycles
   localparam logic [5:0] SH_FIRST    = 6'h1b; // 13.5 cycles
   localparam logic [5:0] SH_NORMAL   = 6'h03; // 1.5 cycles
   localparam logic [5:0] SH_AUTO     = 6'h04; // 2 cycles
   localparam logic [5:0] HALF_LAST   = 6'h02; // Final cycle
   localparam logic [2:0] SRC_DONE    = 3'h0;  // Own done flag

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_CONV = 2'b10
   } conv_state_type;

endpackage : sar_seq_pkg

// File: conv_timing_if.sv
// Purpose: Links sequencer to prescaler and trigger detector
// Assumes: All signals on sys_clk_i except the raw trigger sources
// Notes:   No clocking block; plain nets only
`timescale 1ns/100ps
interface conv_timing_if;
   logic       clear;     // Hold prescaler in reset
   logic [2:0] div_sel;   // Prescale select field
   logic       half_tick; // Every converter clock edge
   logic       rise_tick; // Rising converter clock edge
   logic [2:0] src_sel;   // Trigger source field
   logic [7:0] sources;   // Raw trigger sources
   logic       trig_edge; // Rising edge of selected source

   modport presc (input clear, div_sel,
                  output half_tick, rise_tick);
   modport trig  (input src_sel, sources, output trig_edge);
   modport seq   (output clear, div_sel, src_sel, sources,
                  input half_tick, rise_tick, trig_edge);
endinterface : conv_timing_if

// File: conv_prescaler.sv
// Purpose: Converter clock prescaler with edge ticks
// Assumes: Division 2 for select 0 and 1, else 2**select
// Notes:   Clear restarts at the rising converter edge
`timescale 1ns/100ps
module conv_prescaler
   import sar_seq_pkg::*;
(
   input  wire logic    sys_clk_i,
   input  wire logic    rst_i,
   conv_timing_if.presc tim
);
   // State: cycle count in half period and phase
   typedef struct packed {
      logic [6:0] cnt;   // Cycles within half period
      logic       phase; // One while converter clock low
   } presc_state_type;

   presc_state_type s_r;
   presc_state_type s_nxt;
   logic [6:0]      half_len; // Cycles per half period
   logic            wrap;     // End of a half period

   // Half period length from select
   assign half_len = (tim.div_sel == 3'h0) ? 7'h01 :
                     (7'h01 << (tim.div_sel - 3'h1));
   // Greater-or-equal so a smaller select never stalls the count
   assign wrap = (s_r.cnt >= half_len - 7'h01) & ~tim.clear;
   assign tim.half_tick = wrap;
   assign tim.rise_tick = wrap & s_r.phase;

   // Next state
   always_comb begin
      s_nxt = s_r;
      if (tim.clear) begin
         s_nxt.cnt   = RST_PCNT;
         s_nxt.phase = 1'b0;
      end else if (wrap) begin
         s_nxt.cnt   = RST_PCNT;
         s_nxt.phase = ~s_r.phase;
      end else begin
         s_nxt.cnt = s_r.cnt + 7'h01;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule : conv_prescaler

// File: trig_edge_detect.sv
// Purpose: Synchronise trigger sources, detect rising edge
// Assumes: Sources come from outside this clock domain
// Notes:   Two sync stages plus edge register, edge two cycles late
`timescale 1ns/100ps
module trig_edge_detect
   import sar_seq_pkg::*;
(
   input  wire logic   sys_clk_i,
   input  wire logic   rst_i,
   conv_timing_if.trig tim
);
   // State: two sync stages and previous level
   typedef struct packed {
      logic [7:0] s1;   // First stage, read by s2 only
      logic [7:0] s2;   // Second stage
      logic       prev; // Selected level last cycle
   } trig_state_type;

   trig_state_type s_r;
   trig_state_type s_nxt;

   // Edge of the selected, synchronised source
   assign tim.trig_edge = s_r.s2[tim.src_sel] & ~s_r.prev;

   // Next state
   always_comb begin
      s_nxt      = s_r;
      s_nxt.s1   = tim.sources;
      s_nxt.s2   = s_r.s1;
      s_nxt.prev = s_r.s2[tim.src_sel];
   end

   // State register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule : trig_edge_detect

// File: sar_converter_sequencer.sv
// Purpose: Control and timing of a 10-bit SAR converter
// Assumes: Avalon-MM slave, analog core outside this block
// Notes:   Software and auto-trigger starts, free running
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module sar_converter_sequencer
   import sar_seq_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic [7:1]  trig_src_i,
   input  wire logic [9:0]  core_result_i,
   output logic             core_enable_o,
   output logic             sample_hold_o,
   output logic             conv_active_o,
   output logic [3:0]       channel_o,
   output logic [1:0]       reference_o,
   output logic             irq_o
);
   // ----------------------------------------------------------
   // State
   // ----------------------------------------------------------
   typedef struct packed {
      logic           ack;        // Bus answer cycle
      logic [7:0]     rdata;      // Read data byte
      logic           pwr_reduce; // Converter power reduce bit
      logic           enable;     // Converter enable bit
      logic           start;      // Conversion start bit
      logic           auto_trig;  // Auto trigger enable bit
      logic           done;       // Conversion done flag
      logic           irq_en;     // Interrupt enable
      logic [2:0]     psel;       // Prescale select field
      logic [2:0]     tsrc;       // Trigger source field
      logic [1:0]     tmp_ref;    // Temporary reference select
      logic [3:0]     tmp_chan;   // Temporary channel select
      logic           left_adj;   // Left adjusted readout
      logic [1:0]     act_ref;    // Active reference select
      logic [3:0]     act_chan;   // Active channel select
      logic [9:0]     result;     // Last stored result
      logic           blocked;    // Result updates blocked
      logic           first_pend; // Next is first conversion
      conv_state_type state;      // Sequencer state
      logic [5:0]     total_h;    // Length in half cycles
      logic [5:0]     sh_h;       // Sample instant, halves
      logic [5:0]     half_cnt;   // Halves since start
      logic           sh_pulse;   // Sample-and-hold strobe
   } seq_state_type;

   seq_state_type s_r;   // Registered state
   seq_state_type s_nxt; // Next state

   conv_timing_if tim(); // Links to helper modules

   logic       en_eff;    // Enabled and powered
   logic       acc;       // First cycle of a bus request
   logic       wr_go;     // Write takes effect now
   logic       rd_go;     // Read takes effect now
   logic [5:0] hc_inc;    // Incremented half count
   logic       complete;  // Conversion ends this cycle
   logic       free_run;  // Own done flag as source
   logic       locked;    // Selection held by conversion
   logic [7:0] wbyte;     // Written byte

   // ----------------------------------------------------------
   // Helper modules
   // ----------------------------------------------------------
   conv_prescaler u_presc (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .tim       (tim.presc)
   );

   trig_edge_detect u_trig (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .tim       (tim.trig)
   );

   // ----------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------
   // Low result byte, after adjust
   function automatic logic [7:0] res_lo(
      input logic [9:0] r, input logic adj);
      res_lo = adj ? {r[1:0], 6'h00} : r[7:0];
   endfunction : res_lo

   // High result byte, after adjust
   function automatic logic [7:0] res_hi(
      input logic [9:0] r, input logic adj);
      res_hi = adj ? r[9:2] : {6'h00, r[9:8]};
   endfunction : res_hi

   assign en_eff   = s_r.enable & ~s_r.pwr_reduce;
   assign acc      = (avs_read_i | avs_write_i) & ~s_r.ack;
   assign wr_go    = s_r.ack & avs_write_i
                     & avs_byteenable_i[0];
   assign rd_go    = s_r.ack & avs_read_i;
   assign wbyte    = avs_writedata_i[7:0];
   assign hc_inc   = s_r.half_cnt + 6'h01;
   assign free_run = s_r.auto_trig & (s_r.tsrc == SRC_DONE);
   assign complete = (s_r.state == ST_CONV) & tim.half_tick
                     & (hc_inc == s_r.total_h);
   // lock until the final converter cycle
   assign locked   = (s_r.state == ST_CONV)
                     & (s_r.half_cnt < s_r.total_h - HALF_LAST);

   // Prescaler and trigger wiring
   assign tim.div_sel = s_r.psel;
   assign tim.src_sel = s_r.tsrc;
   assign tim.sources = {trig_src_i, 1'b0};
   assign tim.clear   = ~en_eff
                        | ((s_r.state == ST_IDLE) & s_r.auto_trig
                           & ~s_r.start & tim.trig_edge
                           & (s_r.tsrc != SRC_DONE));

   // ----------------------------------------------------------
   // Bus answer and outputs
   // ----------------------------------------------------------
   // One wait cycle on every access
   assign avs_waitrequest_o = (avs_read_i | avs_write_i)
                              & ~s_r.ack;
   assign avs_readdata_o    = {24'h00_0000, s_r.rdata};
   assign core_enable_o     = en_eff;
   assign sample_hold_o     = s_r.sh_pulse;
   assign conv_active_o     = (s_r.state == ST_CONV);
   assign channel_o         = s_r.act_chan;
   assign reference_o       = s_r.act_ref;
   assign irq_o             = s_r.done & s_r.irq_en;

   // ----------------------------------------------------------
   // Next state
   // ----------------------------------------------------------
   always_comb begin
      s_nxt          = s_r;
      s_nxt.ack      = acc;
      s_nxt.sh_pulse = 1'b0;

      // Read data captured on the first cycle
      if (acc && avs_read_i) begin
         case (avs_address_i)
            OFS_CTRL_A: s_nxt.rdata = {s_r.enable, s_r.start,
               s_r.auto_trig, s_r.done, s_r.irq_en, s_r.psel};
            OFS_CTRL_B: s_nxt.rdata = {5'h00, s_r.tsrc};
            OFS_SEL:    s_nxt.rdata = {s_r.tmp_ref,
               s_r.left_adj, 1'b0, s_r.tmp_chan};
            OFS_RES_LO: s_nxt.rdata = res_lo(s_r.result,
                                             s_r.left_adj);
            OFS_RES_HI: s_nxt.rdata = res_hi(s_r.result,
                                             s_r.left_adj);
            OFS_PWR:    s_nxt.rdata = {7'h00, s_r.pwr_reduce};
            default:    s_nxt.rdata = RST_BYTE;
         endcase
      end

      // low byte read blocks, high unblocks
      if (rd_go && avs_address_i == OFS_RES_LO) begin
         s_nxt.blocked = 1'b1;
      end else if (rd_go && avs_address_i == OFS_RES_HI) begin
         s_nxt.blocked = 1'b0;
      end

      // Register writes
      if (wr_go) begin
         case (avs_address_i)
            OFS_CTRL_A: begin
               s_nxt.enable    = wbyte[CA_ENABLE];
               s_nxt.auto_trig = wbyte[CA_AUTO];
               s_nxt.irq_en    = wbyte[CA_IE];
               s_nxt.psel      = wbyte[2:0];
               if (wbyte[CA_START] && en_eff) begin
                  s_nxt.start = 1'b1;
               end
               // Write one clears the flag
               if (wbyte[CA_DONE]) begin
                  s_nxt.done = 1'b0;
               end
            end
            OFS_CTRL_B: s_nxt.tsrc = wbyte[2:0];
            OFS_SEL: begin
               s_nxt.tmp_ref  = wbyte[7:6];
               s_nxt.left_adj = wbyte[SEL_ADJ];
               s_nxt.tmp_chan = wbyte[3:0];
            end
            OFS_PWR: s_nxt.pwr_reduce = wbyte[PWR_BIT];
            default: ;
         endcase
      end

      if (en_eff && !locked) begin
         s_nxt.act_ref  = s_r.tmp_ref;
         s_nxt.act_chan = s_r.tmp_chan;
      end

      // Sequencer
      case (s_r.state)
         ST_IDLE: begin
            if (s_r.start) begin
               s_nxt.state = ST_WAIT;
            end else if (tim.clear && en_eff) begin
               s_nxt.state    = ST_CONV;
               s_nxt.start    = 1'b1;
               s_nxt.half_cnt = RST_HALF;
               s_nxt.total_h  = s_r.first_pend ? HALF_FIRST
                                               : HALF_AUTO;
               s_nxt.sh_h     = s_r.first_pend ? SH_FIRST
                                               : SH_AUTO;
               s_nxt.first_pend = 1'b0;
            end
         end
         ST_WAIT: begin
            if (tim.rise_tick) begin
               s_nxt.state    = ST_CONV;
               s_nxt.half_cnt = RST_HALF;
               s_nxt.total_h  = s_r.first_pend ? HALF_FIRST
                                               : HALF_NORMAL;
               s_nxt.sh_h     = s_r.first_pend ? SH_FIRST
                                               : SH_NORMAL;
               s_nxt.first_pend = 1'b0;
            end
         end
         ST_CONV: begin
            if (tim.half_tick) begin
               s_nxt.half_cnt = hc_inc;
               if (hc_inc == s_r.sh_h) begin
                  s_nxt.sh_pulse = 1'b1;
               end
            end
            if (complete) begin
               if (!s_r.blocked) begin
                  s_nxt.result = core_result_i;
               end
               if (free_run) begin
                  s_nxt.half_cnt = RST_HALF;
                  s_nxt.total_h  = HALF_NORMAL;
                  s_nxt.sh_h     = SH_NORMAL;
               end else begin
                  s_nxt.start = 1'b0;
                  s_nxt.state = ST_IDLE;
               end
            end
         end
         default: s_nxt.state = ST_IDLE;
      endcase

      // Disabled converter aborts and rearms first timing
      if (!en_eff) begin
         s_nxt.state      = ST_IDLE;
         s_nxt.start      = 1'b0;
         s_nxt.first_pend = 1'b1;
      end

      // flag set wins over a clear
      if (complete) begin
         s_nxt.done = 1'b1;
      end
   end

   // ----------------------------------------------------------
   // State register
   // ----------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_r            <= '0;
         s_r.first_pend <= 1'b1;
         s_r.state      <= ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   property p_busy_start;
      @(posedge sys_clk_i) disable iff (rst_i)
      s_r.state == ST_CONV |-> s_r.start;
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("start bit low during conversion");

   property p_done_set;
      @(posedge sys_clk_i) disable iff (rst_i)
      complete |=> s_r.done;
   endproperty
   a_done_set: assert property (p_done_set)
      else $error("done flag not set at completion");

   property p_single_clear;
      @(posedge sys_clk_i) disable iff (rst_i)
      complete && !free_run && en_eff
      |=> !s_r.start && s_r.state == ST_IDLE;
   endproperty
   a_single_clear: assert property (p_single_clear)
      else $error("start bit not cleared at completion");

   property p_free_run;
      @(posedge sys_clk_i) disable iff (rst_i)
      complete && free_run && en_eff
      |=> s_r.state == ST_CONV && s_r.half_cnt == 6'h00;
   endproperty
   a_free_run: assert property (p_free_run)
      else $error("free running did not restart");

   property p_lock;
      @(posedge sys_clk_i) disable iff (rst_i)
      locked ##1 locked |-> $stable(s_r.act_chan);
   endproperty
   a_lock: assert property (p_lock)
      else $error("channel changed during conversion");

   property p_presc_hold;
      @(posedge sys_clk_i) disable iff (rst_i)
      !en_eff |-> !tim.half_tick ##1 s_r.state == ST_IDLE;
   endproperty
   a_presc_hold: assert property (p_presc_hold)
      else $error("prescaler ran while disabled");

   property p_rise_start;
      @(posedge sys_clk_i) disable iff (rst_i)
      s_r.state == ST_WAIT && tim.rise_tick && en_eff
      |=> s_r.state == ST_CONV;
   endproperty
   a_rise_start: assert property (p_rise_start)
      else $error("no start on rising converter edge");

   property p_edge_ignore;
      @(posedge sys_clk_i) disable iff (rst_i)
      s_r.state == ST_CONV && tim.trig_edge && !complete
      && en_eff |=> s_r.half_cnt == $past(s_r.half_cnt)
      || s_r.half_cnt == $past(hc_inc);
   endproperty
   a_edge_ignore: assert property (p_edge_ignore)
      else $error("busy trigger edge restarted conversion");

   property p_first_len;
      @(posedge sys_clk_i) disable iff (rst_i)
      s_r.state == ST_WAIT && tim.rise_tick && en_eff
      && s_r.first_pend |=> s_r.total_h == 6'h32
      && s_r.sh_h == 6'h1b;
   endproperty
   a_first_len: assert property (p_first_len)
      else $error("first conversion timing wrong");

   property p_blocked;
      @(posedge sys_clk_i) disable iff (rst_i)
      complete && s_r.blocked |=> $stable(s_r.result);
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("result updated while blocked");

   property p_sel_off;
      @(posedge sys_clk_i) disable iff (rst_i)
      !en_eff |=> $stable(s_r.act_chan) && $stable(s_r.act_ref);
   endproperty
   a_sel_off: assert property (p_sel_off)
      else $error("selection applied while disabled");

   c_free_run: cover property (@(posedge sys_clk_i)
      disable iff (rst_i) complete && free_run);
   c_auto: cover property (@(posedge sys_clk_i)
      disable iff (rst_i)
      s_r.state == ST_IDLE ##1 s_r.total_h == 6'h1b
      && s_r.state == ST_CONV);
   c_lost: cover property (@(posedge sys_clk_i)
      disable iff (rst_i) complete && s_r.blocked);

endmodule : sar_converter_sequencer

// File: sar_core_model.sv
// Purpose: Behavioural analog core, returns a tagged code
// Assumes: Code captured at the sample-and-hold pulse
// Notes:   Code scrambles while disabled, like an unpowered core
`timescale 1ns/100ps
module sar_core_model (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   input  wire logic       enable_i,
   input  wire logic       sample_i,
   input  wire logic [3:0] channel_i,
   input  wire logic [1:0] reference_i,
   output logic      [9:0] result_o
);
   // Code carries the selection seen at the sampling instant
   always_ff @(posedge sys_clk_i) begin
      if (rst_i)
         result_o <= 10'h000;
      else if (!enable_i)
         result_o <= ~result_o;
      else if (sample_i)
         result_o <= {reference_i, channel_i, 4'h5};
   end
endmodule : sar_core_model

// File: tb.sv
// Purpose: Self-checking bench of the converter sequencer
// Assumes: Prescale 0 or 2; lengths counted in system clocks
// Notes:   Conversion lengths are queued, checked on fall
`timescale 1ns/100ps
module tb;
   import sar_seq_pkg::*;
   logic        clk, rst, rd, wr, wq, irq, act, sh, en;
   logic [4:0]  adr;
   logic [31:0] wd, q, rdat;
   logic [3:0]  be, ch, ch0, ch1;
   logic [7:1]  trig;
   logic [9:0]  res;
   logic [1:0]  rsel;
   int          errors, n_compared, len, seed;
   bit          free;
   int          exp_q[$];
   sar_converter_sequencer i_sar_converter_sequencer (.sys_clk_i(clk),
      .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .trig_src_i(trig),
      .core_result_i(res), .core_enable_o(en), .sample_hold_o(sh),
      .conv_active_o(act), .channel_o(ch), .reference_o(rsel),
      .irq_o(irq));
   sar_core_model i_sar_core_model (.sys_clk_i(clk), .rst_i(rst),
      .enable_i(en), .sample_i(sh), .channel_i(ch), .reference_i(rsel),
      .result_o(res));
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   // One bus access; held until waitrequest is seen low
   task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= {24'h00_0000, d};
      be <= 4'hf;
      do begin
         @(posedge clk);
      end while (wq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : acc
   task rchk(input string nm, input logic [4:0] a, input logic [7:0] m,
             input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(nm, q & {24'h00_0000, m}, {24'h00_0000, e});
   endtask : rchk
   task wait_irq;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (irq !== 1'b1 && n < 3000);
      chk("irq", irq, 1'b1);
   endtask : wait_irq
   task wrap_up;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Length of each conversion outside free running against the oldest queued note
   always @(posedge clk) begin
      if (act === 1'b1 && !free)
         len++;
      else if (len > 0) begin
         if (exp_q.size() == 0)
            chk("stray_conv", len, 0);
         else
            chk("conv_len", len, exp_q.pop_front());
         len = 0;
      end
   end
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      wrap_up();
   end
   initial begin
      {rst, rd, wr, adr, wd, be, trig, free} = {1'b1, 51'h0};
      seed = 32'h826ab3c5;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rchk("ctrl_a", OFS_CTRL_A, 8'hff, 8'h00);
      rchk("unmapped", 5'h18, 8'hff, 8'h00);
      ch0 = 4'($random(seed));
      ch1 = ~ch0;
      acc(1'b1, OFS_SEL, {4'h4, ch0});
      chk("chan_off", ch, 4'h0);
      acc(1'b1, OFS_CTRL_A, 8'h88);
      exp_q.push_back(50);
      acc(1'b1, OFS_CTRL_A, 8'hc8);
      rchk("busy", OFS_CTRL_A, 8'h40, 8'h40);
      acc(1'b1, OFS_SEL, {4'h4, ch1});
      chk("chan_lock", ch, ch0);
      wait_irq();
      rchk("done", OFS_CTRL_A, 8'h50, 8'h10);
      chk("chan_new", ch, ch1);
      rchk("res_lo", OFS_RES_LO, 8'hff, {ch0, 4'h5});
      rchk("res_hi", OFS_RES_HI, 8'h03, 8'h01);
      exp_q.push_back(52);
      acc(1'b1, OFS_CTRL_A, 8'hda);
      wait_irq();
      acc(1'b1, OFS_CTRL_B, 8'h01);
      acc(1'b1, OFS_CTRL_A, 8'hb8);
      exp_q.push_back(27);
      trig <= 7'h01;
      repeat (8) @(posedge clk);
      trig <= 7'h00;
      repeat (4) @(posedge clk);
      trig <= 7'h01;
      wait_irq();
      repeat (150) @(posedge clk);
      trig <= 7'h00;
      free = 1'b1;
      acc(1'b1, OFS_CTRL_B, 8'h00);
      acc(1'b1, OFS_CTRL_A, 8'hf8);
      repeat (200) @(posedge clk);
      rchk("free_busy", OFS_CTRL_A, 8'h40, 8'h40);
      rchk("blk_lo", OFS_RES_LO, 8'hff, {ch1, 4'h5});
      acc(1'b1, OFS_SEL, {4'h6, ch0});
      repeat (100) @(posedge clk);
      rchk("adj_lo", OFS_RES_LO, 8'hff, 8'h40);
      rchk("adj_hi", OFS_RES_HI, 8'hff, {2'b01, ch1, 2'b01});
      acc(1'b1, OFS_CTRL_A, 8'h00);
      chk("queue", exp_q.size(), 0);
      wrap_up();
   end
endmodule : tb
